//--- rwpg_pkg.sv
package rwpg_pkg;

    // ************************************************************
    // Clock and tick timing
    // ************************************************************
    localparam int CLK_HZ = 125_000_000;
    localparam int BASE_HZ = 10_000_000;
    localparam int TICK_GCD_HZ = 5_000_000;
    // Fractional step so that step/mod of the system clock gives 10 MHz
    localparam logic [5:0] TICK_STEP = 6'(BASE_HZ / TICK_GCD_HZ);
    localparam logic [5:0] TICK_MOD = 6'(CLK_HZ / TICK_GCD_HZ);
    localparam logic [3:0] DEC_LAST = 4'h9;
    localparam int DEC_STAGES = 4;
    localparam logic [5:0] DIV_STEPS = 6'h21;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_PERIOD = 12'h004;
    localparam logic [11:0] OFF_DUTY = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00C;
    localparam logic [11:0] OFF_COUNT = 12'h010;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int CTRL_SEL_LSB = 4;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_OUT_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_SEL_LSB = 4;

    localparam logic RUN_RST = 1'b1;
    localparam logic AUTO_RST = 1'b0;
    localparam logic [31:0] PERIOD_RST = 32'h0000_03E8;
    localparam logic [16:0] DUTY_RST = 17'h0_8000;
    localparam logic [16:0] DUTY_ONE = 17'h1_0000;
    localparam logic [16:0] LOW_MAX = 17'h1_0000;

    // ************************************************************
    // Clock source codes
    // ************************************************************
    typedef enum logic [2:0] {
        clk_sel_ten_meg = 3'h1,
        clk_sel_one_meg = 3'h2,
        clk_sel_hundred_k = 3'h3,
        clk_sel_ten_k = 3'h4,
        clk_sel_one_k = 3'h5
    } rwpg_clk_sel_t;

    localparam rwpg_clk_sel_t SEL_RST = clk_sel_ten_meg;

    typedef enum logic [1:0] {
        CALC_IDLE = 2'b00,
        CALC_START = 2'b01,
        CALC_WAIT = 2'b10
    } rwpg_calc_t;

    // Base ticks (100 ns) per tick of each source
    function automatic logic [13:0] rwpg_divisor(input rwpg_clk_sel_t sel);
        unique case (sel)
            clk_sel_ten_meg: rwpg_divisor = 14'h0001;
            clk_sel_one_meg: rwpg_divisor = 14'h000A;
            clk_sel_hundred_k: rwpg_divisor = 14'h0064;
            clk_sel_ten_k: rwpg_divisor = 14'h03E8;
            default: rwpg_divisor = 14'h2710;
        endcase
    endfunction

    // Fastest source whose 65536-tick span covers the period
    function automatic rwpg_clk_sel_t rwpg_auto_pick(input logic [31:0] per);
        if (per <= 32'h0001_0000)
            rwpg_auto_pick = clk_sel_ten_meg;
        else if (per <= 32'h000A_0000)
            rwpg_auto_pick = clk_sel_one_meg;
        else if (per <= 32'h0064_0000)
            rwpg_auto_pick = clk_sel_hundred_k;
        else if (per <= 32'h03E8_0000)
            rwpg_auto_pick = clk_sel_ten_k;
        else
            rwpg_auto_pick = clk_sel_one_k;
    endfunction

endpackage

//--- rwpg_tick.sv
`timescale 1ns/1ps
module rwpg_tick
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire rwpg_pkg::rwpg_clk_sel_t sel_in,
    output logic tick_out
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [5:0] acc;
        logic [rwpg_pkg::DEC_STAGES-1:0][3:0] cnt;
        logic tick;
    } rwpg_tick_st_t;

    rwpg_tick_st_t s_r;
    rwpg_tick_st_t s_nxt;
    logic [rwpg_pkg::DEC_STAGES:0] tk;
    logic [6:0] acc_sum;

    assign acc_sum = {1'b0, s_r.acc} + {1'b0, rwpg_pkg::TICK_STEP};
    assign tk[0] = (acc_sum >= {1'b0, rwpg_pkg::TICK_MOD});

    // Decade chain: each stage ticks once per ten of the previous
    genvar gi;
    generate
        for (gi = 0; gi < rwpg_pkg::DEC_STAGES; gi++)
        begin : g_dec
            assign tk[gi+1] = tk[gi] & (s_r.cnt[gi] == rwpg_pkg::DEC_LAST);
        end
    endgenerate

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.acc = tk[0] ? 6'(acc_sum - {1'b0, rwpg_pkg::TICK_MOD})
                          : acc_sum[5:0];
        for (int i = 0; i < rwpg_pkg::DEC_STAGES; i++)
        begin
            if (tk[i])
                s_nxt.cnt[i] = (s_r.cnt[i] == rwpg_pkg::DEC_LAST) ? 4'h0
                               : 4'(s_r.cnt[i] + 4'h1);
        end
        unique case (sel_in)
            rwpg_pkg::clk_sel_ten_meg: s_nxt.tick = tk[0];
            rwpg_pkg::clk_sel_one_meg: s_nxt.tick = tk[1];
            rwpg_pkg::clk_sel_hundred_k: s_nxt.tick = tk[2];
            rwpg_pkg::clk_sel_ten_k: s_nxt.tick = tk[3];
            default: s_nxt.tick = tk[4];
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign tick_out = s_r.tick;

endmodule // rwpg_tick

//--- rwpg_div.sv
`timescale 1ns/1ps
module rwpg_div
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [32:0] dividend_in,
    input wire logic [13:0] divisor_in,
    output logic [32:0] quotient_out,
    output logic done_out
);

    // ************************************************************
    // Restoring divider, one quotient bit per clock
    // ************************************************************
    typedef struct packed {
        logic busy;
        logic [5:0] cnt;
        logic [14:0] rem;
        logic [32:0] quo;
        logic [13:0] dvs;
        logic done;
    } rwpg_div_st_t;

    rwpg_div_st_t s_r;
    rwpg_div_st_t s_nxt;
    logic [14:0] shifted;

    assign shifted = {s_r.rem[13:0], s_r.quo[32]};

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (start_in)
        begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt = rwpg_pkg::DIV_STEPS;
            s_nxt.rem = '0;
            s_nxt.quo = dividend_in;
            s_nxt.dvs = divisor_in;
        end
        else if (s_r.busy)
        begin
            s_nxt.quo = {s_r.quo[31:0], 1'b0};
            s_nxt.rem = shifted;
            if (shifted >= {1'b0, s_r.dvs})
            begin
                s_nxt.rem = shifted - {1'b0, s_r.dvs};
                s_nxt.quo[0] = 1'b1;
            end
            s_nxt.cnt = s_r.cnt - 6'h01;
            if (s_r.cnt == 6'h01)
            begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign quotient_out = s_r.quo;
    assign done_out = s_r.done;

endmodule // rwpg_div

//--- rwpg_top.sv
// Overview of operation
// - Stop forces output high immediately
// - Stopped generator ignores all gate triggers
// - Start enables triggering; repeat start harmless
// - Generator runs straight out of reset
// - Period changes the low interval, and in auto mode the source
// - Low count limited to 65536 source ticks
// - Auto clock switch may corrupt pulses
// - Auto mode period limit is 1 kHz's
// - Low interval equals duty times period
// - Source codes one to five, plus auto
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module rwpg_top
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic gate_in,
    output logic pulse_out
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic run;
        logic auto_sel;
        logic [2:0] sel_req;
        logic [31:0] period;
        logic [16:0] duty;
        rwpg_pkg::rwpg_clk_sel_t sel_act;
        rwpg_pkg::rwpg_clk_sel_t sel_calc;
        logic [16:0] low_ticks;
        logic [16:0] count;
        logic pend;
        rwpg_pkg::rwpg_calc_t calc;
        logic gate_d;
        logic pulse;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rwpg_st_t;

    localparam rwpg_st_t ST_RST = '{
        run: rwpg_pkg::RUN_RST,
        auto_sel: rwpg_pkg::AUTO_RST,
        sel_req: rwpg_pkg::SEL_RST,
        period: rwpg_pkg::PERIOD_RST,
        duty: rwpg_pkg::DUTY_RST,
        sel_act: rwpg_pkg::SEL_RST,
        sel_calc: rwpg_pkg::SEL_RST,
        low_ticks: '0,
        count: '0,
        pend: 1'b1,
        calc: rwpg_pkg::CALC_IDLE,
        gate_d: 1'b0,
        pulse: 1'b1,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: '0
    };

    // ************************************************************
    // Signals
    // ************************************************************
    rwpg_st_t s_r;
    rwpg_st_t s_nxt;

    logic tick;
    logic div_start;
    logic div_done;
    logic [32:0] quotient;
    logic [48:0] product;
    logic [32:0] dividend;
    logic [13:0] divisor;

    logic setup;
    logic access;
    logic mapped;
    logic trig;
    logic wr_en;
    logic [31:0] ctrl_view;
    logic [31:0] stat_view;

    // ************************************************************
    // Tick source
    // ************************************************************
    rwpg_tick u_tick
    (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .sel_in(s_r.sel_act),
        .tick_out(tick)
    );

    // ************************************************************
    // Low-time divider
    // ************************************************************
    // Low time in 100 ns units is period times duty (duty in 1/65536)
    assign product = 49'(s_r.period) * 49'(s_r.duty);
    assign dividend = product[48:16];
    // Base ticks per tick of the source being computed for
    assign divisor = rwpg_pkg::rwpg_divisor(s_r.sel_calc);

    rwpg_div u_div
    (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .start_in(div_start),
        .dividend_in(dividend),
        .divisor_in(divisor),
        .quotient_out(quotient),
        .done_out(div_done)
    );

    // ************************************************************
    // Bus decode and read views
    // ************************************************************
    assign setup = psel_in & ~penable_in;
    assign access = psel_in & penable_in & s_r.pready;
    // Refused writes never reach the registers
    assign wr_en = access & pwrite_in & ~s_r.pslverr;

    // Full 12-bit decode; any other address answers with an error
    always_comb
    begin
        unique case (paddr_in)
            rwpg_pkg::OFF_CTRL,
            rwpg_pkg::OFF_PERIOD,
            rwpg_pkg::OFF_DUTY,
            rwpg_pkg::OFF_STATUS,
            rwpg_pkg::OFF_COUNT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read views of the control and status words
    always_comb
    begin
        ctrl_view = '0;
        ctrl_view[rwpg_pkg::CTRL_RUN_BIT] = s_r.run;
        ctrl_view[rwpg_pkg::CTRL_AUTO_BIT] = s_r.auto_sel;
        ctrl_view[rwpg_pkg::CTRL_SEL_LSB +: 3] = s_r.sel_req;
        stat_view = '0;
        stat_view[rwpg_pkg::STAT_RUN_BIT] = s_r.run;
        stat_view[rwpg_pkg::STAT_OUT_BIT] = s_r.pulse;
        stat_view[rwpg_pkg::STAT_BUSY_BIT] =
            (s_r.calc != rwpg_pkg::CALC_IDLE) | s_r.pend;
        stat_view[rwpg_pkg::STAT_SEL_LSB +: 3] = s_r.sel_act;
    end

    // ************************************************************
    // Gate edge
    // ************************************************************
    // Rising edge of the gate; run is checked in the one-shot
    assign trig = gate_in & ~s_r.gate_d;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        s_nxt = s_r;
        div_start = 1'b0;

        // ********************************************************
        // Recompute of low ticks and source after any setting change
        // ********************************************************
        unique case (s_r.calc)
            rwpg_pkg::CALC_IDLE:
            begin
                if (s_r.pend)
                begin
                    s_nxt.pend = 1'b0;
                    s_nxt.calc = rwpg_pkg::CALC_START;
                    if (s_r.auto_sel)
                        s_nxt.sel_calc =
                            rwpg_pkg::rwpg_auto_pick(s_r.period);
                    else if (s_r.sel_req >= 3'(rwpg_pkg::clk_sel_ten_meg) &&
                             s_r.sel_req <= 3'(rwpg_pkg::clk_sel_one_k))
                        s_nxt.sel_calc =
                            rwpg_pkg::rwpg_clk_sel_t'(s_r.sel_req);
                    else
                        s_nxt.sel_calc = rwpg_pkg::clk_sel_ten_meg;
                end
            end
            rwpg_pkg::CALC_START:
            begin
                div_start = 1'b1;
                s_nxt.calc = rwpg_pkg::CALC_WAIT;
            end
            rwpg_pkg::CALC_WAIT:
            begin
                if (div_done)
                begin
                    // Source swaps here; a pulse in flight keeps
                    // counting on the new rate
                    s_nxt.sel_act = s_r.sel_calc;
                    // Low time saturates at 65536 source ticks
                    s_nxt.low_ticks = (quotient > 33'(rwpg_pkg::LOW_MAX))
                        ? rwpg_pkg::LOW_MAX : quotient[16:0];
                    s_nxt.calc = rwpg_pkg::CALC_IDLE;
                end
            end
            default:
            begin
                s_nxt.calc = rwpg_pkg::CALC_IDLE;
            end
        endcase

        // ********************************************************
        // Bus slave: answer one cycle after setup
        // ********************************************************
        s_nxt.pready = setup;
        s_nxt.pslverr = setup & ~mapped;
        if (setup)
        begin
            unique case (paddr_in)
                rwpg_pkg::OFF_CTRL: s_nxt.prdata = ctrl_view;
                rwpg_pkg::OFF_PERIOD: s_nxt.prdata = s_r.period;
                rwpg_pkg::OFF_DUTY: s_nxt.prdata = {15'h0000, s_r.duty};
                rwpg_pkg::OFF_STATUS: s_nxt.prdata = stat_view;
                rwpg_pkg::OFF_COUNT: s_nxt.prdata = {15'h0000, s_r.count};
                default: s_nxt.prdata = '0;
            endcase
        end

        // ********************************************************
        // Writes set pending after the FSM so a new change is never lost
        // ********************************************************
        if (wr_en)
        begin
            unique case (paddr_in)
                rwpg_pkg::OFF_CTRL:
                begin
                    s_nxt.run = pwdata_in[rwpg_pkg::CTRL_RUN_BIT];
                    s_nxt.auto_sel = pwdata_in[rwpg_pkg::CTRL_AUTO_BIT];
                    s_nxt.sel_req = pwdata_in[rwpg_pkg::CTRL_SEL_LSB +: 3];
                    s_nxt.pend = 1'b1;
                end
                rwpg_pkg::OFF_PERIOD:
                begin
                    s_nxt.period = pwdata_in;
                    s_nxt.pend = 1'b1;
                end
                rwpg_pkg::OFF_DUTY:
                begin
                    s_nxt.duty = (pwdata_in[16:0] > rwpg_pkg::DUTY_ONE)
                        ? rwpg_pkg::DUTY_ONE : pwdata_in[16:0];
                    s_nxt.pend = 1'b1;
                end
                default:
                begin
                end
            endcase
        end

        // ********************************************************
        // One-shot output, uses the run value of this very edge
        // ********************************************************
        s_nxt.gate_d = gate_in;
        if (!s_nxt.run)
        begin
            s_nxt.count = '0;
            s_nxt.pulse = 1'b1;
        end
        else if (trig)
        begin
            s_nxt.count = s_r.low_ticks;
            // Zero low ticks: the trigger leaves the output high
            s_nxt.pulse = (s_r.low_ticks == '0);
        end
        else if (tick && s_r.count != '0)
        begin
            s_nxt.count = s_r.count - 17'h0_0001;
            if (s_r.count == 17'h0_0001)
                s_nxt.pulse = 1'b1;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            s_r <= ST_RST;
        else
            s_r <= s_nxt;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata_out = s_r.prdata;
    assign pready_out = s_r.pready;
    assign pslverr_out = s_r.pslverr;
    assign pulse_out = s_r.pulse;

endmodule // rwpg_top

//--- rwpg_top_properties.sv
`timescale 1ns/1ps
module rwpg_top_properties
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic gate_in,
    input wire logic pulse_out
);
    // ****
    // Run state seen from the bus, gate edge
    // ****
    logic gate_r;
    logic run_r;
    logic ctrl_wr;
    logic trig;
    logic bad_addr;
    assign ctrl_wr = psel_in && penable_in && pwrite_in && pready_out
        && paddr_in == 12'h000;
    assign trig = gate_in && !gate_r && run_r;
    assign bad_addr = paddr_in > 12'h010 || paddr_in[1:0] != 2'h0;
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            gate_r <= 1'h0;
            run_r <= 1'h1;
        end
        else
        begin
            gate_r <= gate_in;
            if (ctrl_wr)
                run_r <= pwdata_in[0];
        end
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    sequence s_ctrl_wr;
        ctrl_wr;
    endsequence
    sequence s_stop;
        s_ctrl_wr ##0 !pwdata_in[0];
    endsequence
    property p_stop_high;
        s_stop |=> pulse_out;
    endproperty
    a_stop_high: assert property (p_stop_high)
        else $error("output low after stop");
    property p_stopped_idle;
        !run_r |-> pulse_out;
    endproperty
    a_stopped_idle: assert property (p_stopped_idle)
        else $error("output low while stopped");
    property p_low_needs_trig;
        $fell(pulse_out) |-> $past(trig);
    endproperty
    a_low_needs_trig: assert property (p_low_needs_trig)
        else $error("output fell without trigger");
    property p_retrig_holds;
        trig && !pulse_out |=> !pulse_out;
    endproperty
    a_retrig_holds: assert property (p_retrig_holds)
        else $error("retrigger ended pulse");
    property p_ready_after_setup;
        psel_in && !penable_in |=> pready_out;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("ready missing after setup");
    property p_ready_single;
        pready_out |=> !pready_out;
    endproperty
    a_ready_single: assert property (p_ready_single)
        else $error("ready held two cycles");
    property p_err_map;
        pready_out |-> pslverr_out == bad_addr;
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("error flag wrong for address");
    property p_err_data;
        pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data)
        else $error("nonzero data on refused read");
endmodule // rwpg_top_properties

bind rwpg_top rwpg_top_properties i_props
(
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .gate_in(gate_in),
    .pulse_out(pulse_out)
);

//--- rwpg_gate_src.sv
`timescale 1ns/1ps
module rwpg_gate_src
(
    input wire logic ref_clk_in,
    output logic gate_out
);
    // ****
    // Trigger source: one-cycle high, returns at the trigger edge
    // ****
    initial gate_out = 1'h0;
    task automatic fire();
        @(posedge ref_clk_in);
        gate_out <= 1'h1;
        @(posedge ref_clk_in);
        gate_out <= 1'h0;
    endtask
endmodule // rwpg_gate_src

//--- rwpg_test.sv
`timescale 1ns/1ps
module retriggerable_width_pulse_gen_test;
    logic ref_clk_in;
    logic rst_in;
    logic psel_in;
    logic penable_in;
    logic pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic gate_in;
    logic pulse_out;
    logic [31:0] rdv;
    logic rde;
    int len;
    int err_total = 0;
    int checks = 0;
    int divs[5] = '{1, 10, 100, 1000, 10000};
    logic [31:0] w_per[3] = '{32'h64, 32'h64, 32'hC8};
    logic [31:0] w_duty[3] = '{32'h8000, 32'h4000, 32'h8000};
    int w_ticks[3] = '{50, 25, 100};
    logic [31:0] a_per[5] = '{32'h10000, 32'h10001, 32'hA0001,
        32'h640001, 32'h3E80001};

    rwpg_top i_dut
    (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .gate_in(gate_in),
        .pulse_out(pulse_out)
    );
    rwpg_gate_src i_src
    (
        .ref_clk_in(ref_clk_in),
        .gate_out(gate_in)
    );

    initial
    begin
        ref_clk_in = 1'h0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    // ****
    // Reporting and bus tasks
    // ****
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic hang();
        err_total++;
        wrap_up();
    endtask
    task automatic cmp(string nm, logic [31:0] exp, logic [31:0] seen);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cmp_bit(string nm, logic exp, logic seen);
        cmp(nm, {31'h0, exp}, {31'h0, seen});
    endtask
    task automatic cmp_rng(string nm, logic [31:0] lo, logic [31:0] hi,
        logic [31:0] seen);
        checks++;
        if ((seen >= lo && seen <= hi) !== 1'h1)
        begin
            err_total++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo,
                hi, seen);
        end
    endtask
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int n = 0;
        @(posedge ref_clk_in);
        psel_in <= 1'h1;
        penable_in <= 1'h0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'h1;
        do
        begin
            @(posedge ref_clk_in);
            n++;
            if (n > 50)
                hang();
        end while (pready_out !== 1'h1);
        rdv = prdata_out;
        rde = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic get(logic [11:0] a);
        apb(1'h0, a, 32'h0);
    endtask
    task automatic settle();
        int n = 0;
        do
        begin
            get(rwpg_pkg::OFF_STATUS);
            n++;
            if (n > 100)
                hang();
        end while (rdv[rwpg_pkg::STAT_BUSY_BIT] !== 1'h0);
    endtask
    task automatic low_len();
        int n = 0;
        len = 0;
        #1;
        while (pulse_out !== 1'h0)
        begin
            @(posedge ref_clk_in);
            #1;
            n++;
            if (n > 50)
                hang();
        end
        while (pulse_out === 1'h0)
        begin
            @(posedge ref_clk_in);
            #1;
            len++;
            if (len > 2000)
                hang();
        end
    endtask

    // ****
    // Test sequence
    // ****
    initial
    begin
        rst_in = 1'h1;
        psel_in = 1'h0;
        penable_in = 1'h0;
        pwrite_in = 1'h0;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'h0;
        get(rwpg_pkg::OFF_CTRL);
        cmp("ctrl reset", 32'h11, rdv);
        get(rwpg_pkg::OFF_PERIOD);
        cmp("period reset", 32'h3E8, rdv);
        get(rwpg_pkg::OFF_DUTY);
        cmp("duty reset", 32'h8000, rdv);
        get(12'h014);
        cmp("unmapped data", 32'h0, rdv);
        cmp_bit("unmapped err", 1'h1, rde);
        cmp_bit("idle out", 1'h1, pulse_out);
        for (int i = 0; i < 3; i++)
        begin
            wr(rwpg_pkg::OFF_PERIOD, w_per[i]);
            wr(rwpg_pkg::OFF_DUTY, w_duty[i]);
            settle();
            i_src.fire();
            low_len();
            cmp_rng("low length", 32'(w_ticks[i] * 25 / 2 - 14),
                32'(w_ticks[i] * 25 / 2 + 14), 32'(len));
        end
        wr(rwpg_pkg::OFF_PERIOD, 32'h186A0);
        wr(rwpg_pkg::OFF_DUTY, 32'h8000);
        for (int c = 1; c <= 5; c++)
        begin
            wr(rwpg_pkg::OFF_CTRL, {25'h0, 3'(c), 4'h1});
            settle();
            i_src.fire();
            get(rwpg_pkg::OFF_COUNT);
            cmp_rng("source count", 32'(50000 / divs[c - 1] - 1),
                32'(50000 / divs[c - 1]), rdv);
            wr(rwpg_pkg::OFF_CTRL, {25'h0, 3'(c), 4'h0});
            @(posedge ref_clk_in);
            cmp_bit("stop out", 1'h1, pulse_out);
        end
        i_src.fire();
        repeat (3) @(posedge ref_clk_in);
        cmp_bit("stopped out", 1'h1, pulse_out);
        wr(rwpg_pkg::OFF_DUTY, 32'h1FFFF);
        get(rwpg_pkg::OFF_DUTY);
        cmp("duty clamp", 32'h10000, rdv);
        wr(rwpg_pkg::OFF_PERIOD, 32'h20000);
        wr(rwpg_pkg::OFF_CTRL, 32'h11);
        settle();
        i_src.fire();
        get(rwpg_pkg::OFF_COUNT);
        cmp_rng("count limit", 32'hFFFF, 32'h10000, rdv);
        repeat (40) @(posedge ref_clk_in);
        wr(rwpg_pkg::OFF_CTRL, 32'h11);
        @(posedge ref_clk_in);
        cmp_bit("restart out", 1'h0, pulse_out);
        i_src.fire();
        get(rwpg_pkg::OFF_COUNT);
        cmp_rng("retrigger count", 32'hFFFF, 32'h10000, rdv);
        for (int i = 0; i < 5; i++)
        begin
            wr(rwpg_pkg::OFF_PERIOD, a_per[i]);
            wr(rwpg_pkg::OFF_CTRL, 32'h12);
            settle();
            cmp("auto source", 32'(i + 1), {29'h0, rdv[6:4]});
        end
        wr(rwpg_pkg::OFF_CTRL, 32'h70);
        settle();
        cmp("fallback source", 32'h1, {29'h0, rdv[6:4]});
        wrap_up();
    end
endmodule // retriggerable_width_pulse_gen_test
